// ===== src/fls_pkg.sv
package fls_pkg;
   // array organisation
   localparam int PAGE_COUNT = 1024;
   localparam int PAGE_BYTES = 256;
   localparam int REGION_PAGES = 64;
   localparam int LOCK_COUNT = 16;
   localparam int BUF_BYTES = 128;
   localparam int BUF_WORDS = BUF_BYTES / 4;
   localparam int GP_COUNT = 2;
   localparam int PAGE_W = 10;
   localparam int REGION_LSB = 6;

   // register byte offsets (low 12 address bits)
   localparam logic [11:0] OFS_MODE = 12'h000;
   localparam logic [11:0] OFS_CMD = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_RESULT = 12'h00C;
   localparam logic [11:0] OFS_LOCKS = 12'h010;
   localparam logic [11:0] OFS_NVCFG = 12'h014;
   localparam logic [11:0] OFS_UID = 12'h020;
   localparam logic [11:0] OFS_CALIB = 12'h030;
   localparam logic [11:0] OFS_BUF = 12'h080;

   // field positions
   localparam int MODE_WS_LSB = 0;
   localparam int MODE_NARROW_BIT = 8;
   localparam int CMD_ARG_LSB = 8;
   localparam int ST_READY_BIT = 0;
   localparam int ST_LOCKERR_BIT = 1;
   localparam int ST_CMDERR_BIT = 2;
   localparam logic [31:0] MODE_RST = 32'h0000_0000;

   // command codes
   localparam logic [7:0] CMD_GET_DESC = 8'h00;
   localparam logic [7:0] CMD_PROG_PAGE = 8'h01;
   localparam logic [7:0] CMD_ERASE_PAGE = 8'h02;
   localparam logic [7:0] CMD_ERASE_ALL = 8'h03;
   localparam logic [7:0] CMD_SET_LOCK = 8'h04;
   localparam logic [7:0] CMD_CLR_LOCK = 8'h05;
   localparam logic [7:0] CMD_GET_LOCK = 8'h06;
   localparam logic [7:0] CMD_SET_GP = 8'h07;
   localparam logic [7:0] CMD_CLR_GP = 8'h08;
   localparam logic [7:0] CMD_GET_GP = 8'h09;

   // operation codes towards the array macro
   localparam logic [1:0] OP_PROG = 2'h1;
   localparam logic [1:0] OP_ERASE_PAGE = 2'h2;
   localparam logic [1:0] OP_ERASE_ALL = 2'h3;

   // boot map, 4 Mbyte windows selected by address bits 31:22
   localparam logic [9:0] WIN_BOOT = 10'h000;
   localparam logic [9:0] WIN_FLASH = 10'h001;
   localparam logic [9:0] WIN_ROM = 10'h002;
   localparam logic [31:0] ROM_BASE = 32'h0080_0000;

   // erase input debounce, counted in slow clock ticks
   localparam int SLOW_CLK_HZ = 32768;
   localparam int ERASE_IGNORE_MS = 100;
   localparam int ERASE_VALID_MS = 220;
   localparam int ERASE_IGNORE_TICKS = (ERASE_IGNORE_MS * SLOW_CLK_HZ + 999) / 1000;
   localparam int ERASE_VALID_TICKS = (ERASE_VALID_MS * SLOW_CLK_HZ + 999) / 1000;
   localparam int ERASE_CNT_W = 13;

   typedef enum logic [0:0]
   {
      FLS_IDLE = 1'b0,
      FLS_ARRAY = 1'b1
   } fls_state_e;
endpackage : fls_pkg

// ===== src/fls_ctrl.sv
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
// How it works
// - one bank of 256-byte pages, 1024 pages in this build
// - 128-byte write buffer filled by 32-bit bus writes before programming
// - software picks 128-bit or 64-bit array read width
// - lock regions of 64 pages, 16 lock bits
// - program or erase into locked region aborts and raises interrupt
// - set-lock command sets region lock, clear-lock command clears it
// - valid erase input clears all lock bits
// - config bit 0 set blocks debug and fast programming access
// - security bit set by command only, cleared by erase input plus full erase
// - calibration bits and unique id are read-only, erase input ignores them
// - two config bits, both set by the set-config command with a bit index, only bit 1 cleared by command
// - boot at zero maps flash when config bit 1 set, else ROM
// - valid erase input clears config bit 1
// - ROM always visible at its fixed base
// - fast programming mode when test select and both straps low
// - fast programming port takes read, program, erase, lock, protect commands
// - descriptor command reports flash organisation
// - erase input debounced on slow clock, short pulses ignored
// - erase input triggers full array erase to all ones
module fls_ctrl #(
   parameter int unsigned ERASE_VALID_TICKS_P = fls_pkg::ERASE_VALID_TICKS,
   parameter logic [127:0] UNIQUE_ID = 128'h0001_0203_0405_0607_0809_0A0B_0C0D_0E0F, // arbitrary
   parameter logic [31:0] CALIB_BITS = 32'h0000_5A5A // arbitrary
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic arr_start,
   output logic [1:0] arr_op,
   output logic [fls_pkg::PAGE_W-1:0] arr_page,
   input wire logic arr_done,
   input wire logic [4:0] arr_buf_index,
   output logic [31:0] arr_buf_word,
   output logic arr_wide,
   output logic [3:0] arr_wait_states,
   input wire logic [31:0] fetch_addr,
   output logic sel_flash,
   output logic sel_rom,
   output logic secure_lock,
   output logic lock_abort_irq,
   input wire logic slow_clk,
   input wire logic erase_pin,
   input wire logic factory_test_select,
   input wire logic programming_strap_a,
   input wire logic programming_strap_b,
   output logic fast_prog_mode,
   input wire logic ffp_cmd_valid,
   input wire logic [7:0] ffp_cmd,
   input wire logic [fls_pkg::PAGE_W-1:0] ffp_arg,
   output logic ffp_cmd_ready,
   output logic [31:0] ffp_result,
   output logic ffp_result_valid
);
   import fls_pkg::*;

   fls_state_e state;
   logic [31:0] mode;
   logic [31:0] result;
   logic [LOCK_COUNT-1:0] locks;
   logic [GP_COUNT-1:0] nv_gp;
   logic lock_err;
   logic cmd_err;
   logic [31:0] wbuf [BUF_WORDS];
   logic d_wr;
   logic [11:0] d_addr;
   logic slow_q;
   logic [ERASE_CNT_W-1:0] erase_cnt;
   logic erase_pend;
   logic pin_erase_run;

   // address phase decode; slave never stalls, always answers OKAY
   wire addr_go = hsel & hready & htrans[1];
   wire rd_go = addr_go & ~hwrite;
   wire [11:0] a_ofs = haddr[11:0];
   wire a_hi_zero = (haddr[31:12] == 20'h0_0000);
   wire busy = (state != FLS_IDLE);
   wire wr_cmd = d_wr & (d_addr == OFS_CMD);
   wire wr_mode = d_wr & (d_addr == OFS_MODE);
   wire wr_buf = d_wr & (d_addr[11:7] == OFS_BUF[11:7]) & ~busy;
   wire rd_status = rd_go & a_hi_zero & (a_ofs == OFS_STATUS);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // read mux, evaluated at the address phase so hrdata comes from a flop
   wire [31:0] st_word = {29'h0, cmd_err, lock_err, ~busy};
   wire [31:0] uid_word = UNIQUE_ID[32*a_ofs[3:2] +: 32];
   wire a_buf = (a_ofs[11:7] == OFS_BUF[11:7]);
   wire a_uid = (a_ofs[11:4] == OFS_UID[11:4]);
   wire [31:0] rd_word =
      ~a_hi_zero ? 32'h0000_0000 :
      a_buf ? wbuf[a_ofs[6:2]] :
      a_uid ? uid_word :
      (a_ofs == OFS_MODE) ? mode :
      (a_ofs == OFS_STATUS) ? st_word :
      (a_ofs == OFS_RESULT) ? result :
      (a_ofs == OFS_LOCKS) ? {{(32-LOCK_COUNT){1'b0}}, locks} :
      (a_ofs == OFS_NVCFG) ? {{(32-GP_COUNT){1'b0}}, nv_gp} :
      (a_ofs == OFS_CALIB) ? CALIB_BITS : 32'h0000_0000;

   // command source: bus first, the fast port only when the bus is quiet
   wire fast_ok = fast_prog_mode & ~nv_gp[0];
   assign ffp_cmd_ready = fast_ok & ~busy & ~erase_pend & ~wr_cmd;
   wire bus_start = wr_cmd & ~busy & ~erase_pend;
   wire ffp_start = ffp_cmd_valid & ffp_cmd_ready;
   wire start = bus_start | ffp_start;
   wire [7:0] c_code = bus_start ? hwdata[7:0] : ffp_cmd;
   wire [PAGE_W-1:0] c_arg = bus_start ? hwdata[CMD_ARG_LSB +: PAGE_W] : ffp_arg;
   wire [3:0] c_region = c_arg[PAGE_W-1:REGION_LSB];
   wire c_locked = locks[c_region];
   wire c_prog = (c_code == CMD_PROG_PAGE);
   wire c_epage = (c_code == CMD_ERASE_PAGE);
   wire c_eall = (c_code == CMD_ERASE_ALL);
   wire c_array = c_prog | c_epage | c_eall;
   wire c_abort = ((c_prog | c_epage) & c_locked) | (c_eall & (|locks));
   wire launch_cmd = start & c_array & ~c_abort;
   wire launch_pin = erase_pend & ~busy;
   wire gp_idx_bad = (c_arg > PAGE_W'(GP_COUNT - 1));
   // clearing the security bit by command is refused
   wire gp_clr_bad = gp_idx_bad | (c_arg[0] == 1'b0);
   wire c_set_gp = start & (c_code == CMD_SET_GP) & ~gp_idx_bad;
   wire c_clr_gp = start & (c_code == CMD_CLR_GP) & ~gp_clr_bad;
   wire c_known = (c_code <= CMD_GET_GP);
   wire c_bad = start & (~c_known | (((c_code == CMD_SET_GP) & gp_idx_bad)
      | ((c_code == CMD_CLR_GP) & gp_clr_bad)));

   // descriptor words indexed by the argument
   wire [31:0] desc_word =
      (c_arg[2:0] == 3'h0) ? 32'(PAGE_COUNT) :
      (c_arg[2:0] == 3'h1) ? 32'(PAGE_BYTES) :
      (c_arg[2:0] == 3'h2) ? 32'(REGION_PAGES) :
      (c_arg[2:0] == 3'h3) ? 32'(LOCK_COUNT) :
      (c_arg[2:0] == 3'h4) ? 32'(BUF_BYTES) : 32'h0000_0000;
   wire [31:0] next_result =
      (c_code == CMD_GET_DESC) ? desc_word :
      (c_code == CMD_GET_LOCK) ? {{(32-LOCK_COUNT){1'b0}}, locks} :
      (c_code == CMD_GET_GP) ? {{(32-GP_COUNT){1'b0}}, nv_gp} : 32'h0000_0000;

   // erase input debounce: sampled slow clock gives one tick per period
   wire slow_tick = slow_clk & ~slow_q;
   wire cnt_full = (erase_cnt == ERASE_CNT_W'(ERASE_VALID_TICKS_P));
   wire erase_trig = erase_pin & slow_tick
      & (erase_cnt == ERASE_CNT_W'(ERASE_VALID_TICKS_P - 1));
   wire [ERASE_CNT_W-1:0] next_erase_cnt =
      ~erase_pin ? '0 :
      (slow_tick & ~cnt_full) ? erase_cnt + ERASE_CNT_W'(1) : erase_cnt;

   // lock bits; a valid erase input overrides any command in the same cycle
   logic [LOCK_COUNT-1:0] next_locks;
   always_comb
   begin
      next_locks = locks;
      if (start & (c_code == CMD_SET_LOCK))
      begin
         next_locks[c_region] = 1'b1;
      end
      if (start & (c_code == CMD_CLR_LOCK))
      begin
         next_locks[c_region] = 1'b0;
      end
      if (erase_trig)
      begin
         next_locks = '0;
      end
   end

   // config bits; security clears only once the pin-driven full erase ends
   wire pin_done = (state == FLS_ARRAY) & arr_done & pin_erase_run;
   logic [GP_COUNT-1:0] next_gp;
   always_comb
   begin
      next_gp = nv_gp;
      if (c_set_gp)
      begin
         next_gp[c_arg[0]] = 1'b1;
      end
      if (c_clr_gp)
      begin
         next_gp[1] = 1'b0;
      end
      if (erase_trig)
      begin
         next_gp[1] = 1'b0;
      end
      if (pin_done)
      begin
         next_gp[0] = 1'b0;
      end
   end

   // sticky flags: a new event wins over the read that clears it
   wire next_lock_err = (start & c_abort) | (lock_err & ~rd_status);
   wire next_cmd_err = (wr_cmd & ~bus_start) | c_bad | (cmd_err & ~rd_status);

   // engine: one array operation at a time
   fls_state_e next_state;
   always_comb
   begin
      next_state = state;
      unique case (state)
         FLS_IDLE:
         begin
            if (launch_pin | launch_cmd)
            begin
               next_state = FLS_ARRAY;
            end
         end
         FLS_ARRAY:
         begin
            if (arr_done)
            begin
               next_state = FLS_IDLE;
            end
         end
      endcase
   end

   wire [1:0] next_op = launch_pin ? OP_ERASE_ALL : c_prog ? OP_PROG :
      c_epage ? OP_ERASE_PAGE : OP_ERASE_ALL;

   // boot alias at zero follows config bit 1, ROM window always decodes
   wire [9:0] f_win = fetch_addr[31:22];
   assign sel_rom = (f_win == WIN_ROM) | ((f_win == WIN_BOOT) & ~nv_gp[1]);
   assign sel_flash = (f_win == WIN_FLASH) | ((f_win == WIN_BOOT) & nv_gp[1]);
   assign secure_lock = nv_gp[0];
   assign lock_abort_irq = lock_err;
   assign arr_wide = ~mode[MODE_NARROW_BIT];
   assign arr_wait_states = mode[MODE_WS_LSB +: 4];

   // bus pipeline and read data
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         d_wr <= 1'b0;
         d_addr <= 12'h000;
         hrdata <= 32'h0000_0000;
      end
      else
      begin
         d_wr <= addr_go & hwrite & a_hi_zero;
         d_addr <= a_ofs;
         hrdata <= rd_go ? rd_word : hrdata;
      end
   end

   // write buffer, one word per bus write, frozen while the array runs
   always_ff @(posedge hclk)
   begin
      if (wr_buf)
      begin
         wbuf[d_addr[6:2]] <= hwdata;
      end
      arr_buf_word <= wbuf[arr_buf_index];
   end

   // control and nonvolatile state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= FLS_IDLE;
         mode <= MODE_RST;
         result <= 32'h0000_0000;
         locks <= '0;
         nv_gp <= '0;
         lock_err <= 1'b0;
         cmd_err <= 1'b0;
         arr_start <= 1'b0;
         arr_op <= 2'h0;
         arr_page <= '0;
         pin_erase_run <= 1'b0;
      end
      else
      begin
         state <= next_state;
         mode <= wr_mode ? {23'h0, hwdata[MODE_NARROW_BIT], 4'h0, hwdata[3:0]} : mode;
         result <= start ? next_result : result;
         locks <= next_locks;
         nv_gp <= next_gp;
         lock_err <= next_lock_err;
         cmd_err <= next_cmd_err;
         arr_start <= launch_pin | launch_cmd;
         arr_op <= (launch_pin | launch_cmd) ? next_op : arr_op;
         arr_page <= launch_cmd & ~launch_pin ? c_arg : arr_page;
         pin_erase_run <= launch_pin | (pin_erase_run & ~pin_done);
      end
   end

   // erase input, strap sampling and fast port answer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         slow_q <= 1'b0;
         erase_cnt <= '0;
         erase_pend <= 1'b0;
         fast_prog_mode <= 1'b0;
         ffp_result <= 32'h0000_0000;
         ffp_result_valid <= 1'b0;
      end
      else
      begin
         slow_q <= slow_clk;
         erase_cnt <= next_erase_cnt;
         erase_pend <= erase_trig | (erase_pend & busy);
         fast_prog_mode <= ~factory_test_select & ~programming_strap_a
            & ~programming_strap_b;
         ffp_result <= ffp_start ? next_result : ffp_result;
         ffp_result_valid <= ffp_start;
      end
   end
endmodule : fls_ctrl

// ===== tb/fls_ctrl_sva.sv
`timescale 1ns/1ps
module fls_chk
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic arr_start,
   input wire logic [31:0] fetch_addr,
   input wire logic sel_flash,
   input wire logic sel_rom,
   input wire logic secure_lock,
   input wire logic lock_abort_irq,
   input wire logic factory_test_select,
   input wire logic programming_strap_a,
   input wire logic programming_strap_b,
   input wire logic fast_prog_mode,
   input wire logic ffp_cmd_valid,
   input wire logic ffp_cmd_ready,
   input wire logic ffp_result_valid
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // boot decode is combinational, so windows are checked in the same cycle
   chk_rom_window: assert property (fetch_addr[31:22] == 10'h002 |-> sel_rom && !sel_flash)
      else $error("rom window decode wrong");
   chk_flash_window: assert property (fetch_addr[31:22] == 10'h001 |-> sel_flash && !sel_rom)
      else $error("flash window decode wrong");
   chk_boot_exclusive: assert property (fetch_addr[31:22] == 10'h000 |-> sel_flash ^ sel_rom)
      else $error("boot alias maps to both or none");
   // straps are registered, so mode follows one edge late
   chk_fast_entry: assert property (!(factory_test_select | programming_strap_a |
      programming_strap_b) |=> fast_prog_mode) else $error("fast mode not entered");
   chk_fast_exit: assert property ((factory_test_select | programming_strap_a |
      programming_strap_b) |=> !fast_prog_mode) else $error("fast mode without straps");
   chk_secure_refuse: assert property (secure_lock |-> !ffp_cmd_ready)
      else $error("fast port open while secured");
   chk_ffp_answer: assert property (ffp_cmd_valid && ffp_cmd_ready |=> ffp_result_valid)
      else $error("fast port result missing");
   chk_ffp_cause: assert property ($rose(ffp_result_valid) |-> $past(ffp_cmd_ready))
      else $error("fast port result without command");
   chk_start_busy: assert property (arr_start |-> !ffp_cmd_ready ##1 !arr_start)
      else $error("array start not a lone pulse while busy");
   // main scenarios reached
   cover property (arr_start);
   cover property ($rose(lock_abort_irq));
   cover property (ffp_result_valid);
endmodule : fls_chk
bind fls_ctrl fls_chk fls_chk_i (.*);

// ===== tb/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
   $display("unexpected %0t got %h exp %h", $time, a, b); end end
module tb;
   import fls_pkg::*;
   localparam logic [127:0] UID = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978; // arbitrary
   localparam logic [31:0] CAL = 32'h0000_3C3C; // arbitrary
   logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, arr_done = 1'b0, slow_clk = 1'b0;
   logic erase_pin = 1'b0, ffp_cmd_valid = 1'b0, factory_test_select = 1'b1;
   logic programming_strap_a = 1'b1, programming_strap_b = 1'b1;
   logic hreadyout, hresp, arr_start, arr_wide, sel_flash, sel_rom, secure_lock, lock_abort_irq;
   logic fast_prog_mode, ffp_cmd_ready, ffp_result_valid;
   logic [1:0] htrans = 2'h0, arr_op, xop;
   logic [3:0] arr_wait_states;
   logic [4:0] arr_buf_index = 5'h0;
   logic [7:0] ffp_cmd = 8'h0;
   logic [7:0] ops [3] = '{CMD_PROG_PAGE, CMD_ERASE_PAGE, CMD_ERASE_ALL};
   logic [9:0] ffp_arg = 10'h0, arr_page, xpg;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, fetch_addr = 32'h0;
   logic [31:0] hrdata, arr_buf_word, ffp_result, d;
   logic [31:0] mbuf [32];
   logic [15:0] mlock = 16'h0;
   int bad_count = 0, checked = 0, cyc = 0, seed = 77829, starts = 0, r;
   // kept four-state so an unknown status bit cannot pass as zero
   logic [1:0] err;
   int desc[$] = '{1024, 256, 64, 16, 128};

   fls_ctrl #(.ERASE_VALID_TICKS_P(5), .UNIQUE_ID(UID), .CALIB_BITS(CAL)) fls_ctrl_i
   (
      .hsel(1'b1),
      .hsize(3'h2),
      .hready(hreadyout),
      .*
   );

   // clock and hang guard
   always #5 hclk = ~hclk;
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         conclude();
      end
   end

   task automatic conclude();
      if (bad_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude

   // one single word transfer; read data taken at the data phase edge
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
      `CHK(hresp, 1'b0)
   endtask : bus

   task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
      bus(a, 1'b0, 32'h0);
      `CHK(d, x)
   endtask : rdchk

   // issue a command, poll until ready; sticky error bits are gathered since reads clear them
   task automatic cmd(input logic [7:0] op, input int arg);
      bus(OFS_CMD, 1'b1, {14'h0, arg[9:0], op});
      err = 2'h0;
      do
      begin
         bus(OFS_STATUS, 1'b0, 32'h0);
         err |= d[2:1];
      end
      while (d[0] !== 1'b1);
   endtask : cmd

   // erase input held for a number of slow clock rising edges
   task automatic pulse(input int t);
      erase_pin <= 1'b1;
      repeat (2 * t)
      begin
         repeat (3) @(posedge hclk);
         slow_clk <= ~slow_clk;
      end
      erase_pin <= 1'b0;
   endtask : pulse

   // array stand-in: streams the buffer on program, then answers after a random stall
   always @(posedge hclk)
      if (arr_start === 1'b1)
      begin
         starts++;
         `CHK(arr_op, xop)
         if (xop !== OP_ERASE_ALL) `CHK(arr_page, xpg)
         if (arr_op === OP_PROG)
            for (int i = 0; i < 34; i++)
            begin
               if (i > 1) `CHK(arr_buf_word, mbuf[i - 2])
               arr_buf_index <= 5'(i);
               @(posedge hclk);
            end
         repeat (1 + $unsigned($random(seed)) % 4) @(posedge hclk);
         arr_done <= 1'b1;
         @(posedge hclk);
         arr_done <= 1'b0;
      end

   // main sequence
   initial
   begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      `CHK({arr_wide, arr_wait_states}, 5'h10)
      rdchk(OFS_MODE, MODE_RST);
      bus(OFS_UID, 1'b1, 32'hFFFF_FFFF);
      bus(OFS_CALIB, 1'b1, 32'hFFFF_FFFF);
      rdchk(OFS_UID, UID[31:0]);
      rdchk(OFS_CALIB, CAL);
      rdchk(12'h040, 32'h0);
      for (int i = 0; i < 2; i++)
      begin
         r = $random(seed);
         bus(OFS_MODE, 1'b1, {23'h0, i[0], 4'h0, r[3:0]});
         @(posedge hclk);
         `CHK({arr_wide, arr_wait_states}, {~i[0], r[3:0]})
      end
      foreach (desc[k])
      begin
         cmd(CMD_GET_DESC, k);
         rdchk(OFS_RESULT, 32'(desc[k]));
      end
      for (int i = 0; i < 32; i++)
      begin
         mbuf[i] = $random(seed);
         bus(OFS_BUF + 12'(4 * i), 1'b1, mbuf[i]);
      end
      rdchk(OFS_BUF + 12'h07C, mbuf[31]);
      r = $unsigned($random(seed)) % 16;
      xop = OP_PROG;
      xpg = 10'(r * 64 + 63);
      cmd(CMD_PROG_PAGE, r * 64 + 63);
      // locked region refuses every program and erase kind
      cmd(CMD_SET_LOCK, r * 64);
      mlock[r] = 1'b1;
      rdchk(OFS_LOCKS, {16'h0, mlock});
      cmd(CMD_GET_LOCK, 0);
      rdchk(OFS_RESULT, {16'h0, mlock});
      foreach (ops[k])
      begin
         cmd(ops[k], r * 64 + 63);
         `CHK(err, 1)
      end
      // abort flag stands until software reads the status word
      bus(OFS_CMD, 1'b1, {14'h0, 10'(r * 64), CMD_ERASE_PAGE});
      @(posedge hclk);
      `CHK(lock_abort_irq, 1'b1)
      rdchk(OFS_STATUS, 32'h0000_0003);
      `CHK(lock_abort_irq, 1'b0)
      `CHK(starts, 1)
      xop = OP_ERASE_PAGE;
      xpg = 10'((r * 64 + 64) % 1024);
      cmd(CMD_ERASE_PAGE, (r * 64 + 64) % 1024);
      `CHK(err, 0)
      cmd(CMD_CLR_LOCK, r * 64 + 32);
      rdchk(OFS_LOCKS, 32'h0);
      // boot alias follows config bit 1, rom base fixed
      cmd(CMD_SET_GP, 1);
      @(posedge hclk);
      `CHK({sel_flash, sel_rom}, 2'b10)
      cmd(CMD_CLR_GP, 1);
      @(posedge hclk);
      `CHK({sel_flash, sel_rom}, 2'b01)
      fetch_addr <= 32'h0080_0000;
      cmd(CMD_SET_GP, 1);
      `CHK({sel_flash, sel_rom}, 2'b01)
      // fast port answers until secured
      {factory_test_select, programming_strap_a, programming_strap_b} <= 3'h0;
      ffp_cmd_valid <= 1'b1;
      ffp_cmd <= CMD_GET_DESC;
      do @(posedge hclk); while (ffp_cmd_ready !== 1'b1);
      ffp_cmd_valid <= 1'b0;
      @(posedge hclk);
      `CHK({fast_prog_mode, ffp_result_valid, ffp_result}, {2'b11, 32'h0000_0400})
      cmd(CMD_SET_GP, 0);
      `CHK({secure_lock, ffp_cmd_ready}, 2'b10)
      cmd(CMD_CLR_GP, 0);
      `CHK(err, 2)
      rdchk(OFS_NVCFG, 32'h3);
      cmd(CMD_GET_GP, 0);
      rdchk(OFS_RESULT, 32'h3);
      // undefined opcode is refused with the command error bit
      cmd(8'hA5, 0);
      `CHK(err, 2)
      // short erase pulse ignored, long one clears locks, boot bit and security
      cmd(CMD_SET_LOCK, 1023);
      pulse(3);
      rdchk(OFS_LOCKS, 32'h0000_8000);
      xop = OP_ERASE_ALL;
      pulse(7);
      do @(posedge hclk); while (secure_lock !== 1'b0);
      `CHK(starts, 3)
      rdchk(OFS_LOCKS, 32'h0);
      rdchk(OFS_NVCFG, 32'h0);
      fetch_addr <= 32'h0;
      @(posedge hclk);
      @(posedge hclk);
      `CHK({sel_flash, sel_rom}, 2'b01)
      conclude();
   end
endmodule : tb
